// File: rtl/eprom_host_pkg.sv
/*
 * constants for the uv eprom programmer / reader host controller.
 * assumes a 125 MHz core clock and a device of 2048 x 8 words.
 */
package eprom_host_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int WORDS = 2048;
    localparam int CLK_PERIOD_NS = 8;
    // program pulse, nominal and limits in ms
    localparam int PULSE_NOM_MS = 50;
    localparam int PULSE_MIN_MS = 45;
    localparam int PULSE_MAX_MS = 55;
    localparam int NS_PER_MS = 1000000;
    localparam int PULSE_NOM_CYC = PULSE_NOM_MS * (NS_PER_MS / CLK_PERIOD_NS);
    localparam int PULSE_MIN_CYC = (PULSE_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_MAX_CYC = PULSE_MAX_MS * (NS_PER_MS / CLK_PERIOD_NS);
    // set-up / hold around the pulse and around supply switching, in us
    localparam int SETUP_US = 2;
    localparam int HOLD_US = 2;
    localparam int NS_PER_US = 1000;
    localparam int SETUP_CYC = (SETUP_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC = (HOLD_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // read access: address / select to data 450 ns worst case
    localparam int ACCESS_NS = 450;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam logic [DATA_W-1:0] ERASED_WORD = 8'hff;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_RD_ACC = 4'h1,
        ST_PG_SETUP = 4'h3,
        ST_PG_PULSE = 4'h2,
        ST_PG_HOLD = 4'h6,
        ST_VF_ACC = 4'h7,
        ST_DONE = 4'h5
    } state_t;
endpackage

// File: rtl/cycle_timer.sv
/*
 * down counter: load a count, raises expired when it reaches zero.
 * assumes one synchronous clock and reset.
 */
`timescale 1ns/1ps
module cycle_timer #(
    parameter int W = 24
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic expired
);
    logic [W-1:0] cnt_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= value;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    // no load term here: the caller's load depends on expired
    assign expired = (cnt_r == '0);
endmodule

// File: rtl/eprom_host.sv
/*
 * host controller driving a 2048 x 8 uv eprom through its pins:
 * read, program (single pulse per word) and program verify.
 * assumes the eprom pins and a supply switch sit outside; data pins are
 * split into in / out / output enable (low = driving).
 */
`timescale 1ns/1ps
module eprom_host
    import eprom_host_pkg::*;
#(
    parameter int PULSE_CYC = PULSE_NOM_CYC,
    parameter int SETUP_CYCLES = SETUP_CYC,
    parameter int HOLD_CYCLES = HOLD_CYC,
    parameter int ACCESS_CYCLES = ACCESS_CYC
) (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic RESET,
    // command port
    input wire logic CMD_READ,
    input wire logic CMD_PROG,
    input wire logic [ADDR_W-1:0] CMD_ADDR,
    input wire logic [DATA_W-1:0] CMD_DATA,
    output logic CMD_BUSY,
    output logic RSP_VALID,
    output logic [DATA_W-1:0] RSP_DATA,
    output logic RSP_ERROR,
    // eprom pins
    output logic [ADDR_W-1:0] ROM_ADDR,
    output logic SELECT_PROGRAM_STROBE,
    output logic OUTPUT_ENABLE_N,
    output logic VPP_HIGH,
    input wire logic [DATA_W-1:0] ROM_DATA_IN,
    output logic [DATA_W-1:0] ROM_DATA_OUT,
    output logic ROM_DATA_OE_N
);
    state_t state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic strobe_r;
    logic oe_n_r;
    logic vpp_r;
    logic drive_n_r;
    logic valid_r;
    logic err_r;
    logic [DATA_W-1:0] rdata_r;
    logic tload;
    logic [CNT_W-1:0] tval;
    logic texp;
    logic busy_r;

    // expected readback: the word read must equal the programmed word in every bit
    function automatic logic verify_ok(input logic [DATA_W-1:0] want,
                                       input logic [DATA_W-1:0] got);
        verify_ok = (got == want);
    endfunction

    cycle_timer #(.W(CNT_W)) u_timer (
        .clk(CORE_CLK),
        .rst(RESET),
        .load(tload),
        .value(tval),
        .expired(texp)
    );

    // ==========================================================
    // sequencer
    always_comb begin
        tload = 1'b0;
        tval = '0;
        case (state_r)
            ST_IDLE: begin
                if (CMD_READ) begin
                    tload = 1'b1;
                    tval = CNT_W'(ACCESS_CYCLES);
                end else if (CMD_PROG) begin
                    tload = 1'b1;
                    tval = CNT_W'(SETUP_CYCLES);
                end
            end
            ST_PG_SETUP: begin
                if (texp) begin
                    tload = 1'b1;
                    // strobe stays up through the zero count: load one less
                    tval = CNT_W'(PULSE_CYC - 1);
                end
            end
            ST_PG_PULSE: begin
                if (texp) begin
                    tload = 1'b1;
                    tval = CNT_W'(HOLD_CYCLES);
                end
            end
            ST_PG_HOLD: begin
                if (texp) begin
                    tload = 1'b1;
                    tval = CNT_W'(ACCESS_CYCLES);
                end
            end
            default: begin
                tload = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (CMD_READ) begin
                        state_r <= ST_RD_ACC;
                    end else if (CMD_PROG) begin
                        state_r <= ST_PG_SETUP;
                    end
                end
                ST_RD_ACC: if (texp) state_r <= ST_DONE;
                ST_PG_SETUP: if (texp) state_r <= ST_PG_PULSE;
                ST_PG_PULSE: if (texp) state_r <= ST_PG_HOLD;
                ST_PG_HOLD: if (texp) state_r <= ST_VF_ACC;
                ST_VF_ACC: if (texp) state_r <= ST_DONE;
                ST_DONE: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // busy flag, registered copy of state not idle
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            busy_r <= 1'b0;
        end else if (state_r == ST_IDLE && (CMD_READ || CMD_PROG)) begin
            busy_r <= 1'b1;
        end else if (state_r == ST_DONE) begin
            busy_r <= 1'b0;
        end
    end

    // ==========================================================
    // pin drive
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            addr_r <= '0;
            wdata_r <= ERASED_WORD;
        end else if (state_r == ST_IDLE && (CMD_READ || CMD_PROG)) begin
            addr_r <= CMD_ADDR;
            wdata_r <= CMD_DATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            strobe_r <= 1'b1;
            oe_n_r <= 1'b1;
            vpp_r <= 1'b0;
            drive_n_r <= 1'b1;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    strobe_r <= !(CMD_READ || CMD_PROG);
                    oe_n_r <= !CMD_READ;
                    vpp_r <= CMD_PROG && !CMD_READ;
                    drive_n_r <= !(CMD_PROG && !CMD_READ);
                end
                ST_RD_ACC: begin
                    strobe_r <= 1'b0;
                    oe_n_r <= 1'b0;
                end
                ST_PG_SETUP: begin
                    strobe_r <= texp;
                    oe_n_r <= 1'b1;
                end
                ST_PG_PULSE: begin
                    strobe_r <= !texp;
                end
                ST_PG_HOLD: begin
                    strobe_r <= 1'b0;
                    drive_n_r <= texp;
                    oe_n_r <= !texp;
                end
                ST_VF_ACC: begin
                    oe_n_r <= 1'b0;
                    if (texp) begin
                        vpp_r <= 1'b0;
                    end
                end
                default: begin
                    strobe_r <= 1'b1;
                    oe_n_r <= 1'b1;
                    vpp_r <= 1'b0;
                    drive_n_r <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // response
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            valid_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            valid_r <= 1'b0;
            if ((state_r == ST_RD_ACC || state_r == ST_VF_ACC) && texp) begin
                valid_r <= 1'b1;
                rdata_r <= ROM_DATA_IN;
                err_r <= (state_r == ST_VF_ACC) && !verify_ok(wdata_r, ROM_DATA_IN);
            end
        end
    end

    assign ROM_ADDR = addr_r;
    assign SELECT_PROGRAM_STROBE = strobe_r;
    assign OUTPUT_ENABLE_N = oe_n_r;
    assign VPP_HIGH = vpp_r;
    assign ROM_DATA_OUT = wdata_r;
    assign ROM_DATA_OE_N = drive_n_r;
    assign CMD_BUSY = busy_r;
    assign RSP_VALID = valid_r;
    assign RSP_DATA = rdata_r;
    assign RSP_ERROR = err_r;

    // ==========================================================
    // checks
    property p_pulse_quiet;
        @(posedge CORE_CLK) disable iff (RESET)
        $rose(strobe_r) && vpp_r |-> oe_n_r && !drive_n_r;
    endproperty
    a_pulse_quiet: assert property (p_pulse_quiet) else $error("pulse without program setup");

    property p_stable_pulse;
        @(posedge CORE_CLK) disable iff (RESET)
        strobe_r && vpp_r && $past(strobe_r) |-> $stable(addr_r) && $stable(wdata_r);
    endproperty
    a_stable_pulse: assert property (p_stable_pulse) else $error("address or data moved in pulse");

    property p_no_contention;
        @(posedge CORE_CLK) disable iff (RESET)
        !(oe_n_r == 1'b0 && drive_n_r == 1'b0);
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("both ends drive data");

    property p_vpp_only_prog;
        @(posedge CORE_CLK) disable iff (RESET)
        state_r == ST_IDLE |-> !vpp_r;
    endproperty
    a_vpp_only_prog: assert property (p_vpp_only_prog) else $error("high supply while idle");

    sequence s_pulse_end;
        state_r == ST_PG_PULSE && texp;
    endsequence
    property p_verify_follows;
        @(posedge CORE_CLK) disable iff (RESET)
        s_pulse_end |-> ##[1:1000] (state_r == ST_VF_ACC);
    endproperty
    a_verify_follows: assert property (p_verify_follows) else $error("no verify after program");

    property p_standby_idle;
        @(posedge CORE_CLK) disable iff (RESET)
        state_r == ST_DONE |=> strobe_r && oe_n_r && !vpp_r && drive_n_r;
    endproperty
    a_standby_idle: assert property (p_standby_idle) else $error("standby pins wrong");

    property p_read_drive;
        @(posedge CORE_CLK) disable iff (RESET)
        state_r == ST_RD_ACC |-> !strobe_r && !oe_n_r && !vpp_r && drive_n_r;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("read pins wrong");

    property p_verify_pins;
        @(posedge CORE_CLK) disable iff (RESET)
        state_r == ST_VF_ACC && !texp |-> !strobe_r && !oe_n_r && vpp_r;
    endproperty
    a_verify_pins: assert property (p_verify_pins) else $error("verify pins wrong");
endmodule

// File: testbench/eprom_model.sv
/*
 * behavioural 2048 x 8 uv eprom on the far side of the host controller.
 * assumes the host pins connect directly; protocol faults are counted.
 */
`timescale 1ns/1ps
module eprom_model
    import eprom_host_pkg::*;
#(
    parameter real PW_MIN_NS = 720.0,
    parameter real PW_MAX_NS = 880.0
) (
    // device pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic strobe,
    input wire logic oe_n,
    input wire logic vpp_high,
    input wire logic [DATA_W-1:0] dq_in,
    input wire logic host_drive_n,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_en,
    // fault count
    output int faults
);
    logic [DATA_W-1:0] mem [WORDS];
    logic [ADDR_W-1:0] addr_d;
    logic en_d;
    logic in_pulse;
    logic [ADDR_W-1:0] pg_addr;
    logic [DATA_W-1:0] pg_data;
    realtime t_rise;
    initial begin
        faults = 0;
        in_pulse = 0;
        foreach (mem[i]) mem[i] = ERASED_WORD;
    end
    // ========================================
    // output stage, garbage until access time
    assign dq_en = !strobe && !oe_n;
    assign #(ACCESS_NS) addr_d = addr;
    assign #(ACCESS_NS) en_d = dq_en;
    assign dq_out = (en_d && addr_d === addr) ? mem[addr] : ~mem[addr];
    always @(dq_en, host_drive_n) begin
        #1 if (dq_en && !host_drive_n) faults++;
    end
    // ========================================
    // program pulse, inhibit while strobe low
    always @(posedge strobe) begin
        in_pulse = vpp_high && oe_n;
        t_rise = $realtime;
        pg_addr = addr;
        pg_data = dq_in;
    end
    always @(negedge strobe) begin
        if (in_pulse) begin
            if ($realtime - t_rise < PW_MIN_NS || $realtime - t_rise > PW_MAX_NS) faults++;
            if (addr !== pg_addr || dq_in !== pg_data || !oe_n || !vpp_high) faults++;
            mem[pg_addr] = mem[pg_addr] & pg_data;
        end
        in_pulse = 0;
    end
endmodule

// File: testbench/eprom_host_test.sv
/*
 * self-checking bench: host controller against the eprom model.
 * assumes package, design and model files are compiled first.
 */
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin compares++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module eprom_host_test;
    import eprom_host_pkg::*;
    localparam int PULSE = 100;
    localparam real PW_NS = PULSE * CLK_PERIOD_NS;
    logic clk = 0, rst = 1, cmd_read = 0, cmd_prog = 0;
    logic [ADDR_W-1:0] cmd_addr = '0, rom_addr;
    logic [DATA_W-1:0] cmd_data = '0, rsp_data, rom_data_in, data_out, dq_out;
    logic [DATA_W-1:0] float_pat = 8'h00, got;
    logic busy, rsp_valid, rsp_error, strobe, oe_n, vpp_high, data_oe_n, dq_en, err;
    int faults, mismatches = 0, compares = 0;
    always #(CLK_PERIOD_NS / 2.0) clk = ~clk;
    // ========================================
    // data pin resolution, floating bus wanders
    always @(posedge clk) float_pat <= float_pat + 8'h3b;
    assign rom_data_in = !data_oe_n ? data_out : (dq_en ? dq_out : float_pat);
    eprom_host #(.PULSE_CYC(PULSE), .SETUP_CYCLES(4), .HOLD_CYCLES(4)) i_eprom_host (
        .CORE_CLK(clk), .RESET(rst), .CMD_READ(cmd_read), .CMD_PROG(cmd_prog),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .CMD_BUSY(busy), .RSP_VALID(rsp_valid),
        .RSP_DATA(rsp_data), .RSP_ERROR(rsp_error), .ROM_ADDR(rom_addr),
        .SELECT_PROGRAM_STROBE(strobe), .OUTPUT_ENABLE_N(oe_n), .VPP_HIGH(vpp_high),
        .ROM_DATA_IN(rom_data_in), .ROM_DATA_OUT(data_out), .ROM_DATA_OE_N(data_oe_n));
    eprom_model #(.PW_MIN_NS(PW_NS * 0.9), .PW_MAX_NS(PW_NS * 1.1)) i_eprom_model (
        .addr(rom_addr), .strobe(strobe), .oe_n(oe_n), .vpp_high(vpp_high),
        .dq_in(rom_data_in), .host_drive_n(data_oe_n), .dq_out(dq_out), .dq_en(dq_en),
        .faults(faults));
    // ========================================
    // one command; poke raises program while a read is busy
    task automatic do_cmd(input logic rd, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, input logic poke);
        int n;
        int hi;
        n = 0;
        hi = 0;
        @(posedge clk);
        #1 cmd_read = rd;
        cmd_prog = !rd;
        cmd_addr = a;
        cmd_data = d;
        @(posedge clk);
        #1 cmd_read = 0;
        cmd_prog = 0;
        if (poke) begin
            repeat (3) @(posedge clk);
            #1 cmd_prog = 1;
            @(posedge clk);
            #1 cmd_prog = 0;
        end
        while (rsp_valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
            if (!rd && strobe === 1'b1 && vpp_high === 1'b1) begin
                hi++;
                if (hi == 1) `CHECK("program pins", {2'b10, a, d}, {oe_n, data_oe_n, rom_addr, data_out})
            end
        end
        if (n >= 1000) mismatches++;
        if (!rd) `CHECK("pulse cycles", PULSE, hi)
        got = rsp_data;
        err = rsp_error;
        while (busy !== 1'b0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        `CHECK("supply idle", 1'b0, vpp_high)
    endtask
    task automatic t_reset;
        @(negedge clk);
        `CHECK("idle pins", 5'b11010, {strobe, oe_n, vpp_high, data_oe_n, busy})
        `CHECK("model drive", 1'b0, dq_en)
    endtask
    task automatic t_read_erased;
        do_cmd(1, 11'h000, 8'h00, 0);
        `CHECK("erased low", ERASED_WORD, got)
        do_cmd(1, 11'h7ff, 8'h00, 0);
        `CHECK("erased top", ERASED_WORD, got)
    endtask
    task automatic t_prog_verify;
        do_cmd(0, 11'h005, 8'h5a, 0);
        `CHECK("verify word", 9'h05a, {err, got})
        do_cmd(1, 11'h005, 8'h00, 0);
        `CHECK("read back", 8'h5a, got)
    endtask
    task automatic t_prog_clears;
        do_cmd(0, 11'h005, 8'hf0, 0);
        `CHECK("verify cleared", 9'h150, {err, got})
    endtask
    task automatic t_prog_any_order;
        do_cmd(0, 11'h7ff, 8'h00, 0);
        do_cmd(0, 11'h003, 8'ha5, 0);
        do_cmd(1, 11'h003, 8'h00, 0);
        `CHECK("word 3", 8'ha5, got)
        do_cmd(1, 11'h7ff, 8'h00, 0);
        `CHECK("top word", 8'h00, got)
    endtask
    task automatic t_busy_refused;
        do_cmd(1, 11'h009, 8'h00, 1);
        do_cmd(1, 11'h009, 8'h00, 0);
        `CHECK("untouched word", ERASED_WORD, got)
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        #1 rst = 0;
        t_reset();
        t_read_erased();
        t_prog_verify();
        t_prog_clears();
        t_prog_any_order();
        t_busy_refused();
        `CHECK("model faults", 0, faults)
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
